// file: inc/rsfs_pkg.sv
// constants and types shared by the reset sequencer and flash security block
`default_nettype none

package rsfs_pkg;

   // staged release timing, in system clock cycles
   localparam int unsigned STAGE_CYCLES = 32;
   localparam int unsigned POR_STRETCH_CYCLES_DEFAULT = 2097152;
   localparam int CNT_W = 22;

   // reset sequencer states, gray coded along the power-on release path through the stretch state
   typedef enum logic [2:0] {
      RSFS_ST_HOLD    = 3'h0,
      RSFS_ST_STRETCH = 3'h1,
      RSFS_ST_SIMCLK  = 3'h3,
      RSFS_ST_PERIPH  = 3'h2,
      RSFS_ST_CORE    = 3'h6,
      RSFS_ST_RUN     = 3'h7
   } rsfs_state_t;

   // stop and wait disable field encodings in the system control register
   localparam int CTRL_MODE_W = 2;
   localparam logic [1:0] CTRL_ENABLED = 2'h0;
   localparam logic [1:0] CTRL_DIS_TEMP = 2'h1;
   localparam logic [1:0] CTRL_DIS_PERM = 2'h2;

   // security byte layout
   localparam int SEC_BYTE_W = 8;
   localparam int SEC_FIELD_LSB = 0;
   localparam int SEC_FIELD_W = 2;
   localparam logic [1:0] SEC_UNSECURED_CODE = 2'h2;
   localparam int KEY_FIELD_LSB = 6;
   localparam int KEY_FIELD_W = 2;
   localparam logic [1:0] KEY_ENABLE_CODE = 2'h2;

   // jtag flash divider layout
   localparam int JDIV_W = 7;
   localparam int JDIV_PRESCALE_BIT = 6;
   localparam int DIV_RATIO_W = 6;

endpackage : rsfs_pkg

`default_nettype wire

// file: core/rsfs_async_sync.sv
// reset synchroniser: asserts asynchronously, releases on the second clock edge
`default_nettype none

module rsfs_async_sync (
   // clock
   input wire logic clock_i,
   // asynchronous active low reset pin
   input wire logic async_rst_n_i,
   // synchronised active high reset
   output logic sync_rst_o
);

   typedef struct packed {
      logic meta;
      logic sync;
   } rsfs_sync_t;

   rsfs_sync_t sync_reg;
   rsfs_sync_t sync_next;

   always_comb begin
      sync_next.meta = 1'b0;
      sync_next.sync = sync_reg.meta;
   end

   always_ff @(posedge clock_i or negedge async_rst_n_i) begin
      if (!async_rst_n_i) begin
         sync_reg <= '{meta: 1'b1, sync: 1'b1};
      end else begin
         sync_reg <= sync_next;
      end
   end

   assign sync_rst_o = sync_reg.sync;

   property p_sync_release;
      @(posedge clock_i) disable iff (!async_rst_n_i)
         $fell(sync_rst_o) |-> $past(async_rst_n_i, 1) && $past(async_rst_n_i, 2);
   endproperty
   a_sync_release: assert property (p_sync_release)
      else $error("reset released without two clocked samples of the pin");

endmodule // rsfs_async_sync

`default_nettype wire

// file: core/rsfs_top.sv
// reset sequencer with stop/wait disable, flash security and lockout recovery
`default_nettype none

// Overview of operation
// - four reset sources, two async two sync
// - power-on reset stretched two to the twenty-first cycles by default
// - then 32 cycles starting system clocking
// - then 32 cycles releasing peripherals, security applied
// - then 32 cycles core init, then run
// - pin synchronisers assert asynchronously, staged outputs change on clock edge
// - software may disable stop and wait
// - permanent disable cleared by next reset
// - stop never shuts the pll itself
// - secured part loses debug emulation and memory reads
// - security decided by two persistent bytes
// - boot selects unsecured or secure mode
// - jtag tap always active at boot
// - security bytes drive memory read disable
// - recovery mass erase clears security
// - recovery loads seven bit divider first
// - jtag divider overrides flash clock divider
// - erase starts in run test idle
// - backdoor unlock only with key enable
module rsfs_top
#(
   parameter int unsigned POR_STRETCH_CYCLES = rsfs_pkg::POR_STRETCH_CYCLES_DEFAULT
) (
   // clock and reset
   input wire logic clock_i,
   input wire logic reset_i,
   // reset sources
   input wire logic ext_reset_n_i,
   input wire logic por_n_i,
   input wire logic watchdog_reset_i,
   // system control register write
   input wire logic ctrl_write_i,
   input wire logic ctrl_sw_reset_i,
   input wire logic [rsfs_pkg::CTRL_MODE_W-1:0] ctrl_stop_mode_i,
   input wire logic [rsfs_pkg::CTRL_MODE_W-1:0] ctrl_wait_mode_i,
   // flash security bytes and backdoor
   input wire logic [rsfs_pkg::SEC_BYTE_W-1:0] security_byte0_i,
   input wire logic [rsfs_pkg::SEC_BYTE_W-1:0] security_byte1_i,
   input wire logic backdoor_unlock_i,
   // jtag lockout recovery
   input wire logic lockout_ir_sel_i,
   input wire logic jtag_dr_update_i,
   input wire logic [rsfs_pkg::JDIV_W-1:0] jtag_flash_divider_i,
   input wire logic tap_run_idle_i,
   input wire logic tap_reset_i,
   input wire logic flash_erase_done_i,
   // staged reset outputs
   output logic sys_clock_en_o,
   output logic periph_reset_o,
   output logic core_reset_o,
   output logic core_run_o,
   // sleep instruction control
   output logic stop_disable_o,
   output logic wait_disable_o,
   // security outputs
   output logic secure_mode_o,
   output logic debug_port_enable_o,
   output logic mem_read_disable_o,
   output logic tap_enable_o,
   output logic backdoor_key_enable_o,
   // flash divider override and erase
   output logic mass_erase_req_o,
   output logic divider_override_o,
   output logic prescale_by_eight_o,
   output logic [rsfs_pkg::DIV_RATIO_W-1:0] div_ratio_o,
   output logic recovery_done_o
);
   import rsfs_pkg::*;

   localparam logic [CNT_W-1:0] STAGE_LAST = CNT_W'(STAGE_CYCLES - 1);
   localparam logic [CNT_W-1:0] STRETCH_LAST = CNT_W'(POR_STRETCH_CYCLES - 1);

   typedef struct packed {
      rsfs_state_t state;
      logic [CNT_W-1:0] cnt;
      logic por_seen;
      logic [CTRL_MODE_W-1:0] stop_mode;
      logic [CTRL_MODE_W-1:0] wait_mode;
      logic secure;
      logic debug_en;
      logic key_en;
      logic [JDIV_W-1:0] jtag_div;
      logic div_loaded;
      logic erasing;
      logic rec_done;
      logic sys_clk_en;
      logic periph_rst;
      logic core_rst;
      logic core_run;
      logic stop_dis;
      logic wait_dis;
   } rsfs_regs_t;

   localparam rsfs_regs_t REGS_RESET = '{
      state: RSFS_ST_HOLD,
      cnt: '0,
      por_seen: 1'b1,
      stop_mode: CTRL_ENABLED,
      wait_mode: CTRL_ENABLED,
      secure: 1'b1,
      debug_en: 1'b0,
      key_en: 1'b0,
      jtag_div: '0,
      div_loaded: 1'b0,
      erasing: 1'b0,
      rec_done: 1'b0,
      sys_clk_en: 1'b0,
      periph_rst: 1'b1,
      core_rst: 1'b1,
      core_run: 1'b0,
      stop_dis: 1'b0,
      wait_dis: 1'b0
   };

   rsfs_regs_t regs_reg;
   rsfs_regs_t regs_next;

   logic por_sync;
   logic ext_sync;
   logic sw_reset;
   logic src_any;

   // async pins pass a two flop synchroniser before any logic
   rsfs_async_sync u_por_sync (
      .clock_i(clock_i),
      .async_rst_n_i(por_n_i),
      .sync_rst_o(por_sync)
   );

   rsfs_async_sync u_ext_sync (
      .clock_i(clock_i),
      .async_rst_n_i(ext_reset_n_i),
      .sync_rst_o(ext_sync)
   );

   assign sw_reset = ctrl_write_i & ctrl_sw_reset_i;
   assign src_any = por_sync | ext_sync | watchdog_reset_i | sw_reset;

   always_comb begin
      regs_next = regs_reg;
      case (regs_reg.state)
         RSFS_ST_HOLD: begin
            regs_next.cnt = '0;
            if (regs_reg.por_seen) begin
               regs_next.state = RSFS_ST_STRETCH;
            end else begin
               regs_next.state = RSFS_ST_SIMCLK;
            end
         end
         RSFS_ST_STRETCH: begin
            if (regs_reg.cnt == STRETCH_LAST) begin
               regs_next.state = RSFS_ST_SIMCLK;
               regs_next.cnt = '0;
               regs_next.por_seen = 1'b0;
            end else begin
               regs_next.cnt = regs_reg.cnt + 1'b1;
            end
         end
         RSFS_ST_SIMCLK: begin
            if (regs_reg.cnt == STAGE_LAST) begin
               regs_next.state = RSFS_ST_PERIPH;
               regs_next.cnt = '0;
               // security decided from the bytes while the core is held
               regs_next.secure = security_byte0_i[SEC_FIELD_LSB +: SEC_FIELD_W]
                  != SEC_UNSECURED_CODE;
               regs_next.key_en = security_byte1_i[KEY_FIELD_LSB +: KEY_FIELD_W]
                  == KEY_ENABLE_CODE;
            end else begin
               regs_next.cnt = regs_reg.cnt + 1'b1;
            end
         end
         RSFS_ST_PERIPH: begin
            if (regs_reg.cnt == STAGE_LAST) begin
               regs_next.state = RSFS_ST_CORE;
               regs_next.cnt = '0;
            end else begin
               regs_next.cnt = regs_reg.cnt + 1'b1;
            end
         end
         RSFS_ST_CORE: begin
            if (regs_reg.cnt == STAGE_LAST) begin
               regs_next.state = RSFS_ST_RUN;
               regs_next.cnt = '0;
            end else begin
               regs_next.cnt = regs_reg.cnt + 1'b1;
            end
         end
         RSFS_ST_RUN: begin
            regs_next.cnt = '0;
         end
         default: begin
            regs_next.state = RSFS_ST_HOLD;
            regs_next.cnt = '0;
         end
      endcase
      if (por_sync) begin
         regs_next.por_seen = 1'b1;
      end

      // stop/wait disable; the pll is never touched here
      if (ctrl_write_i) begin
         if (regs_reg.stop_mode != CTRL_DIS_PERM) begin
            regs_next.stop_mode = ctrl_stop_mode_i;
         end
         if (regs_reg.wait_mode != CTRL_DIS_PERM) begin
            regs_next.wait_mode = ctrl_wait_mode_i;
         end
      end

      // backdoor key unlock, honoured only with key enable set
      if (backdoor_unlock_i && regs_reg.key_en) begin
         regs_next.secure = 1'b0;
      end

      // lockout recovery
      if (jtag_dr_update_i && lockout_ir_sel_i && !regs_reg.erasing) begin
         regs_next.jtag_div = jtag_flash_divider_i;
         regs_next.div_loaded = 1'b1;
      end
      if (regs_reg.erasing) begin
         if (flash_erase_done_i) begin
            regs_next.erasing = 1'b0;
            regs_next.rec_done = 1'b1;
            regs_next.secure = 1'b0;
         end else if (!tap_run_idle_i || !lockout_ir_sel_i) begin
            regs_next.erasing = 1'b0;
         end
      end else if (regs_reg.div_loaded && lockout_ir_sel_i && tap_run_idle_i
                   && !regs_reg.rec_done) begin
         regs_next.erasing = 1'b1;
      end
      if (tap_reset_i) begin
         regs_next.div_loaded = 1'b0;
         regs_next.erasing = 1'b0;
         regs_next.rec_done = 1'b0;
      end

      // any active source holds the first stage and clears sleep disables
      if (src_any) begin
         regs_next.state = RSFS_ST_HOLD;
         regs_next.cnt = '0;
         regs_next.stop_mode = CTRL_ENABLED;
         regs_next.wait_mode = CTRL_ENABLED;
      end

      // registered outputs follow the next state
      regs_next.sys_clk_en = !(regs_next.state inside {RSFS_ST_HOLD, RSFS_ST_STRETCH});
      regs_next.periph_rst = !(regs_next.state inside
         {RSFS_ST_PERIPH, RSFS_ST_CORE, RSFS_ST_RUN});
      regs_next.core_rst = !(regs_next.state inside {RSFS_ST_CORE, RSFS_ST_RUN});
      regs_next.core_run = regs_next.state == RSFS_ST_RUN;
      regs_next.stop_dis = regs_next.stop_mode != CTRL_ENABLED;
      regs_next.wait_dis = regs_next.wait_mode != CTRL_ENABLED;
      regs_next.debug_en = !regs_next.secure;
   end

   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         regs_reg <= REGS_RESET;
      end else begin
         regs_reg <= regs_next;
      end
   end

   assign sys_clock_en_o = regs_reg.sys_clk_en;
   assign periph_reset_o = regs_reg.periph_rst;
   assign core_reset_o = regs_reg.core_rst;
   assign core_run_o = regs_reg.core_run;
   assign stop_disable_o = regs_reg.stop_dis;
   assign wait_disable_o = regs_reg.wait_dis;
   assign secure_mode_o = regs_reg.secure;
   assign debug_port_enable_o = regs_reg.debug_en;
   assign mem_read_disable_o = regs_reg.secure;
   assign tap_enable_o = 1'b1;
   assign backdoor_key_enable_o = regs_reg.key_en;
   assign mass_erase_req_o = regs_reg.erasing;
   assign divider_override_o = regs_reg.erasing;
   assign prescale_by_eight_o = regs_reg.jtag_div[JDIV_PRESCALE_BIT];
   assign div_ratio_o = regs_reg.jtag_div[DIV_RATIO_W-1:0];
   assign recovery_done_o = regs_reg.rec_done;

   default clocking cb_main @(posedge clock_i);
   endclocking
   default disable iff (reset_i);

   property p_source_holds;
      src_any |=> regs_reg.state == RSFS_ST_HOLD && periph_reset_o && core_reset_o;
   endproperty
   a_source_holds: assert property (p_source_holds)
      else $error("active reset source did not hold the sequencer");
   property p_stretch_holds;
      (regs_reg.state == RSFS_ST_STRETCH && regs_reg.cnt != STRETCH_LAST && !src_any)
         |=> regs_reg.state == RSFS_ST_STRETCH && !sys_clock_en_o;
   endproperty
   a_stretch_holds: assert property (p_stretch_holds)
      else $error("power-on stretch ended early");
   sequence s_clk_started;
      $rose(sys_clock_en_o);
   endsequence
   sequence s_periph_after_stage;
      ##31 periph_reset_o ##1 !periph_reset_o;
   endsequence
   property p_simclk_stage;
      disable iff (reset_i || src_any)
      s_clk_started |-> s_periph_after_stage;
   endproperty
   a_simclk_stage: assert property (p_simclk_stage)
      else $error("clock start stage not 32 cycles");
   sequence s_periph_released;
      $fell(periph_reset_o);
   endsequence
   sequence s_core_after_stage;
      ##31 core_reset_o ##1 !core_reset_o;
   endsequence
   property p_periph_stage;
      disable iff (reset_i || src_any)
      s_periph_released |-> s_core_after_stage;
   endproperty
   a_periph_stage: assert property (p_periph_stage)
      else $error("peripheral release stage not 32 cycles");
   property p_core_stage;
      disable iff (reset_i || src_any)
      $fell(core_reset_o) |-> !core_run_o [*8] ##24 !core_run_o ##1 core_run_o;
   endproperty
   a_core_stage: assert property (p_core_stage)
      else $error("core run not 32 cycles after core release");
   property p_perm_lock;
      (regs_reg.stop_mode == CTRL_DIS_PERM && ctrl_write_i && !src_any)
         |=> stop_disable_o;
   endproperty
   a_perm_lock: assert property (p_perm_lock)
      else $error("permanent stop disable was overwritten");
   property p_debug_blocked;
      secure_mode_o |-> !debug_port_enable_o && mem_read_disable_o;
   endproperty
   a_debug_blocked: assert property (p_debug_blocked)
      else $error("debug port open while secured");
   property p_backdoor_gate;
      (secure_mode_o && backdoor_unlock_i && !backdoor_key_enable_o && !regs_reg.erasing
         && regs_reg.state != RSFS_ST_SIMCLK) |=> secure_mode_o;
   endproperty
   a_backdoor_gate: assert property (p_backdoor_gate)
      else $error("backdoor unlock without key enable");
   property p_erase_start;
      (regs_reg.div_loaded && lockout_ir_sel_i && tap_run_idle_i && !recovery_done_o
         && !tap_reset_i && !flash_erase_done_i) |=> mass_erase_req_o;
   endproperty
   a_erase_start: assert property (p_erase_start)
      else $error("erase did not start in run-test/idle");
   property p_erase_clears;
      (mass_erase_req_o && flash_erase_done_i && !tap_reset_i)
         |=> !secure_mode_o && recovery_done_o && !mass_erase_req_o;
   endproperty
   a_erase_clears: assert property (p_erase_clears)
      else $error("completed erase did not clear security");

endmodule // rsfs_top

`default_nettype wire

// file: bench/rsfs_host_model.sv
// partner model: jtag host, external reset source and flash erase response
`default_nettype none

module rsfs_host_model #(
   parameter int ERASE_CYCLES = 20
) (
   // clock
   input wire logic clock_i,
   // erase request from the block
   input wire logic mass_erase_req_i,
   // reset pin and jtag side
   output logic ext_reset_n_o,
   output logic ir_sel_o,
   output logic dr_update_o,
   output logic [6:0] divider_o,
   output logic run_idle_o,
   output logic tap_reset_o,
   // flash erase completion
   output logic erase_done_o
);
   timeunit 1ns;
   timeprecision 1ps;
   int cnt = 0;

   initial begin
      ext_reset_n_o = 1'b1;
      ir_sel_o = 1'b0;
      dr_update_o = 1'b0;
      divider_o = 7'h00;
      run_idle_o = 1'b0;
      tap_reset_o = 1'b0;
      erase_done_o = 1'b0;
   end

   // flash reports a finished erase a fixed time after the request
   always @(negedge clock_i) begin
      cnt <= mass_erase_req_i ? cnt + 1 : 0;
      erase_done_o <= mass_erase_req_i && cnt == ERASE_CYCLES;
   end

   task automatic set_pin(input logic v);
      ext_reset_n_o = v;
   endtask

   // instruction, then divider data if load is set, then stay in run-test/idle
   task automatic recover(input logic [6:0] div, input logic load);
      @(negedge clock_i);
      ir_sel_o = 1'b1;
      if (load) begin
         @(negedge clock_i);
         dr_update_o = 1'b1;
         divider_o = div;
         @(negedge clock_i);
         dr_update_o = 1'b0;
         divider_o = ~div;
      end
      @(negedge clock_i);
      run_idle_o = 1'b1;
   endtask

   // tap reset then external chip reset once recovery is over
   task automatic finish();
      @(negedge clock_i);
      tap_reset_o = 1'b1;
      run_idle_o = 1'b0;
      ir_sel_o = 1'b0;
      @(negedge clock_i);
      tap_reset_o = 1'b0;
      ext_reset_n_o = 1'b0;
      repeat (3) @(negedge clock_i);
      ext_reset_n_o = 1'b1;
   endtask
endmodule // rsfs_host_model

`default_nettype wire

// file: bench/tb_reset_sequencer_flash_security.sv
// testbench for the reset sequencer and flash security block
`default_nettype none

module tb_reset_sequencer_flash_security;
   timeunit 1ns;
   timeprecision 1ps;
   import rsfs_pkg::*;
   localparam int POR_N = 64;
   logic clock_i = 0, reset_i = 1, por_n = 1, wd = 0, cw = 0, csw = 0, unlock = 0;
   logic [1:0] sm = 0, wm = 0;
   logic [7:0] b0 = 0, b1 = 0;
   logic ext_n, ir, dru, rti, trst, done;
   logic [6:0] jdiv;
   logic sce, prst, crst, run, sd, wdis, sec, dbg, mrd, tap, key, er, ovr, p8, rd;
   logic [5:0] dr;
   int n_errors = 0, comparisons = 0, cyc = 0;

   rsfs_top #(.POR_STRETCH_CYCLES(POR_N)) u_dut (
      .clock_i(clock_i), .reset_i(reset_i), .ext_reset_n_i(ext_n), .por_n_i(por_n),
      .watchdog_reset_i(wd), .ctrl_write_i(cw), .ctrl_sw_reset_i(csw),
      .ctrl_stop_mode_i(sm), .ctrl_wait_mode_i(wm), .security_byte0_i(b0),
      .security_byte1_i(b1), .backdoor_unlock_i(unlock), .lockout_ir_sel_i(ir),
      .jtag_dr_update_i(dru), .jtag_flash_divider_i(jdiv), .tap_run_idle_i(rti),
      .tap_reset_i(trst), .flash_erase_done_i(done), .sys_clock_en_o(sce),
      .periph_reset_o(prst), .core_reset_o(crst), .core_run_o(run),
      .stop_disable_o(sd), .wait_disable_o(wdis), .secure_mode_o(sec),
      .debug_port_enable_o(dbg), .mem_read_disable_o(mrd), .tap_enable_o(tap),
      .backdoor_key_enable_o(key), .mass_erase_req_o(er), .divider_override_o(ovr),
      .prescale_by_eight_o(p8), .div_ratio_o(dr), .recovery_done_o(rd));

   rsfs_host_model u_host (
      .clock_i(clock_i), .mass_erase_req_i(er), .ext_reset_n_o(ext_n), .ir_sel_o(ir),
      .dr_update_o(dru), .divider_o(jdiv), .run_idle_o(rti), .tap_reset_o(trst),
      .erase_done_o(done));

   initial forever #2.5 clock_i = ~clock_i;

   task automatic summarize();
      $display("errors %0d comparisons %0d", n_errors, comparisons);
      if (n_errors == 0 && comparisons > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   always @(posedge clock_i) begin
      cyc++;
      if (cyc == 10000) begin
         n_errors++;
         summarize();
      end
   end

   task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
      comparisons++;
      if (got !== exp) begin
         n_errors++;
         $display("unexpected %s: expected %0h, seen %0h", what, exp, got);
      end
   endtask

   task automatic check_n(input string what, input int exp, input int got);
      comparisons++;
      if (got != exp) begin
         n_errors++;
         $display("unexpected %s: expected %0d, seen %0d", what, exp, got);
      end
   endtask

   function automatic logic stage_sig(input int s);
      case (s)
         0: return sce;
         1: return !prst;
         2: return !crst;
         3: return run;
         default: return rd;
      endcase
   endfunction

   task automatic wait_until(input int s, output int n);
      n = 0;
      while (stage_sig(s) !== 1'b1 && n < 3000) begin
         @(negedge clock_i);
         n++;
      end
   endtask

   task automatic seq_check(output int t0);
      int n;
      wait_until(0, t0);
      for (int s = 1; s < 4; s++) begin
         wait_until(s, n);
         check_n("stage length", STAGE_CYCLES, n);
      end
   endtask

   task automatic wr(input logic [1:0] s, input logic [1:0] w);
      @(negedge clock_i);
      cw = 1;
      sm = s;
      wm = w;
      @(negedge clock_i);
      cw = 0;
   endtask

   task automatic sources();
      int t[4];
      for (int s = 0; s < 4; s++) begin
         @(negedge clock_i);
         case (s)
            0: por_n = 0;
            1: u_host.set_pin(1'b0);
            2: wd = 1;
            default: begin
               cw = 1;
               csw = 1;
            end
         endcase
         @(negedge clock_i);
         cw = 0;
         csw = 0;
         @(negedge clock_i);
         check("run in reset", 8'h00, run);
         if (s < 3) begin
            repeat (6) @(negedge clock_i);
            check("clock en held", 8'h00, sce);
         end
         por_n = 1;
         wd = 0;
         u_host.set_pin(1'b1);
         seq_check(t[s]);
      end
      check_n("por stretch", POR_N, t[0] - t[1]);
   endtask

   task automatic ctrl();
      int t;
      for (int m = 0; m < 4; m++) begin
         wr(2'(m), (m % 2) ? 2'h0 : 2'(3 - m));
         check("stop dis", 8'(m != 0), sd);
         check("wait dis", 8'(m % 2 == 0), wdis);
      end
      wr(CTRL_DIS_PERM, CTRL_DIS_TEMP);
      wr(CTRL_ENABLED, CTRL_ENABLED);
      check("perm stop", 8'h01, sd);
      check("temp wait", 8'h00, wdis);
      @(negedge clock_i);
      wd = 1;
      @(negedge clock_i);
      wd = 0;
      @(negedge clock_i);
      check("perm cleared", 8'h00, sd);
      seq_check(t);
   endtask

   task automatic boot(input logic [7:0] v0, input logic [7:0] v1);
      int t;
      b1 = v1;
      b0 = v0;
      u_host.set_pin(1'b0);
      repeat (3) @(negedge clock_i);
      u_host.set_pin(1'b1);
      seq_check(t);
   endtask

   task automatic security();
      logic s, k;
      for (int c = 0; c < 4; c++) begin
         boot({6'h15, 2'(c)}, {2'(c + 1), 6'h2a});
         s = 2'(c) != SEC_UNSECURED_CODE;
         k = 2'(c + 1) == KEY_ENABLE_CODE;
         check("sec outs", {4'h0, s, !s, s, 1'b1}, {4'h0, sec, dbg, mrd, tap});
         check("key en", 8'(k), key);
         @(negedge clock_i);
         unlock = 1;
         @(negedge clock_i);
         unlock = 0;
         check("after unlock", 8'(s && !k), sec);
      end
   endtask

   task automatic recovery();
      int n;
      boot(8'h00, 8'h00);
      u_host.recover(7'h49, 1'b0);
      repeat (4) @(negedge clock_i);
      check("erase unloaded", 8'h00, er);
      u_host.finish();
      seq_check(n);
      u_host.recover(7'h49, 1'b1);
      repeat (2) @(negedge clock_i);
      check("erase on", 8'h03, {er, ovr});
      check("divider", 8'h49, {p8, dr});
      wait_until(4, n);
      check("erase end", 8'h02, {er, rd, sec});
      u_host.finish();
      check("done cleared", 8'h00, rd);
      seq_check(n);
   endtask

   initial begin
      int t;
      repeat (6) @(negedge clock_i);
      check("reset a", 8'h62, {sce, prst, crst, run, sd, wdis, sec, dbg});
      check("reset b", 8'h60, {1'b0, mrd, tap, key, er, ovr, p8, rd});
      reset_i = 0;
      seq_check(t);
      sources();
      ctrl();
      security();
      recovery();
      summarize();
   end
endmodule // tb_reset_sequencer_flash_security

`default_nettype wire
